// File: rtl/hub_serial_port_interrupt_logic.sv
`timescale 1ns/10ps
`include "hub_irq_defines.svh"

module hub_serial_port_interrupt_logic
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port from the serial slave engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_write_data,
    output logic [7:0] reg_read_data,
    // Hub events, same clock
    input wire logic suspend_state,
    input wire logic configured_state,
    input wire logic port_power_written,
    input wire logic charger_found_low,
    input wire logic detection_finished,
    // Pin mode configuration
    input wire logic irq_as_suspend_level,
    // Address select pins
    input wire logic addr_select_upper_pin,
    input wire logic addr_select_lower_pin,
    // Outputs
    output logic irq_low,
    output logic [6:0] slave_address
);

    hub_irq_pkg::irq_state_type state;
    hub_irq_pkg::irq_state_type next_state;

    event_bus_if bus ();

    logic status_write;
    logic enable_write;
    logic summary_clear;
    logic unmasked_rise;

    function automatic logic hits(input logic [7:0] addr,
                                  input logic [7:0] offset);
        hits = (addr == offset);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Event capture
    assign bus.raw[`SUSPEND_BIT] = suspend_state;
    assign bus.raw[`CONFIGURED_BIT] = configured_state;
    assign bus.raw[`PORT_POWER_BIT] = port_power_written;
    assign bus.raw[`CHARGER_FOUND_BIT] = ~charger_found_low;
    assign bus.raw[`DETECT_DONE_BIT] = detection_finished;

    // Zero written to a flag bit clears it; one leaves it
    assign bus.clear = status_write ? ~reg_write_data[`EVENT_COUNT-1:0]
                                    : '0;

    event_capture u_capture
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .bus(bus.capture)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    assign status_write = reg_write && hits(reg_addr, `STATUS_OFFSET);
    assign enable_write = reg_write && hits(reg_addr, `ENABLE_OFFSET);
    assign summary_clear = status_write && !reg_write_data[`SUMMARY_BIT];
    assign unmasked_rise = |(bus.rise & state.enables);

    always_comb
    begin
        next_state = state;

        // Address select pins through two stages
        next_state.asel_meta = {addr_select_upper_pin, addr_select_lower_pin};
        next_state.asel_sync = state.asel_meta;
        next_state.slave_address = {state.asel_sync[1] ? `ADDRESS_UPPER_SEL1
                                                       : `ADDRESS_UPPER_SEL0,
                                    state.asel_sync[0]};

        if (enable_write)
            next_state.enables = reg_write_data[`EVENT_COUNT-1:0];

        // New unmasked event wins over a clear in the same cycle
        next_state.summary = unmasked_rise
                             || (state.summary && !summary_clear);

        if (irq_as_suspend_level)
            next_state.irq_low = ~suspend_state;
        else
            next_state.irq_low = ~next_state.summary;

        if (reg_read)
        begin
            if (hits(reg_addr, `STATUS_OFFSET))
                next_state.read_data = {state.summary, 2'b00,
                                        bus.flags};
            else if (hits(reg_addr, `ENABLE_OFFSET))
                next_state.read_data = {3'b000, state.enables};
            else if (hits(reg_addr, `ADDRESS_OFFSET))
                next_state.read_data = {1'b0, `ADDRESS_UPPER_SEL0,
                                        1'b0};
            else
                next_state.read_data = `UNMAPPED_READ;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state.summary <= 1'(`STATUS_RESET >> `SUMMARY_BIT);
            state.enables <= `ENABLE_RESET;
            state.read_data <= `UNMAPPED_READ;
            state.irq_low <= 1'b1;
            state.asel_meta <= 2'b00;
            state.asel_sync <= 2'b00;
            state.slave_address <= {`ADDRESS_UPPER_SEL0, 1'b0};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign reg_read_data = state.read_data;
    assign irq_low = state.irq_low;
    assign slave_address = state.slave_address;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_summary_mirrors_pin: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !$past(irq_as_suspend_level) |-> (irq_low == !state.summary))
    else $error("summary bit and pin disagree");

    a_zero_write_release: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        summary_clear && !unmasked_rise && !irq_as_suspend_level
        |=> irq_low && !state.summary)
    else $error("zero write did not release pin");

    a_one_write_keeps: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        status_write && reg_write_data[`SUMMARY_BIT] && state.summary
        |=> state.summary)
    else $error("one write changed summary");

    a_enabled_event_fires: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        |(bus.rise & state.enables) && !irq_as_suspend_level
        |=> !irq_low ##1 (state.summary || $past(summary_clear)))
    else $error("enabled event did not pull pin low");

    a_masked_event_quiet: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !state.summary && !unmasked_rise |=> !state.summary)
    else $error("summary set without enabled event");

    a_pin_stays_low: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !irq_low && !$past(irq_as_suspend_level)
        && |(bus.flags & state.enables) && !summary_clear
        && !irq_as_suspend_level
        |=> !irq_low)
    else $error("pin released while enabled flag pending");

    a_addr_reads_const: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        reg_read && hits(reg_addr, `ADDRESS_OFFSET)
        |=> reg_read_data == `ADDRESS_RESET)
    else $error("address register read wrong");

    a_slave_addr_lsb: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        addr_select_lower_pin [*4] |-> slave_address[0])
    else $error("slave address low bit not from pin");

    a_suspend_level_mode: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        irq_as_suspend_level |=> irq_low == !$past(suspend_state))
    else $error("pin not following suspend level");

endmodule

// File: pkg/hub_irq_defines.svh
`ifndef HUB_IRQ_DEFINES_SVH
`define HUB_IRQ_DEFINES_SVH
// How it works
// - Summary bit reads one once an unmasked event has pulled the pin low.
// - Writing zero to summary releases the pin; writing one changes nothing.
// - Suspend flag sets on suspend entry, clears only on zero write.
// - Configured flag sets when host configures hub, clears on zero write.
// - Port-power flag sets on port power update, clears on zero write.
// - Charger-found flag sets when low-active charger indication asserts.
// - Detect-done flag sets when detection finished rises, clears on zero.
// - Suspend enable bit lets suspend entry pull the pin low.
// - Configured enable bit lets configuration pull the pin low.
// - Port-power enable bit lets port power updates pull the pin low.
// - Charger-found enable bit lets charger detection pull the pin low.
// - Detect-done enable bit lets detection completion pull the pin low.
// - Address register returns read-only upper six address bits for select low.
// - Seven-bit slave address takes its bottom bit from lower select pin.
// - Suspend-level mode turns the pin into a plain suspend indication.

// Event count and bit positions
`define EVENT_COUNT 5
`define SUMMARY_BIT 7
`define SUSPEND_BIT 4
`define CONFIGURED_BIT 3
`define PORT_POWER_BIT 2
`define CHARGER_FOUND_BIT 1
`define DETECT_DONE_BIT 0

// Register offsets
`define STATUS_OFFSET 8'he8
`define ENABLE_OFFSET 8'he9
`define ADDRESS_OFFSET 8'hea

// Reset values
`define STATUS_RESET 8'h00
`define ENABLE_RESET 5'h00
`define ADDRESS_RESET 8'h08
`define UNMAPPED_READ 8'h00

// Upper six slave address bits for each upper select level
`define ADDRESS_UPPER_SEL0 6'h04
`define ADDRESS_UPPER_SEL1 6'h14
`endif

// File: pkg/hub_irq_pkg.sv
`include "hub_irq_defines.svh"

package hub_irq_pkg;

    typedef struct packed {
        logic [`EVENT_COUNT-1:0] prev;
        logic [`EVENT_COUNT-1:0] flags;
    } capture_state_type;

    typedef struct packed {
        logic summary;
        logic [`EVENT_COUNT-1:0] enables;
        logic [7:0] read_data;
        logic irq_low;
        logic [1:0] asel_meta;
        logic [1:0] asel_sync;
        logic [6:0] slave_address;
    } irq_state_type;

endpackage

// File: pkg/event_bus_if.sv
`timescale 1ns/10ps
`include "hub_irq_defines.svh"

interface event_bus_if;
    logic [`EVENT_COUNT-1:0] raw;
    logic [`EVENT_COUNT-1:0] clear;
    logic [`EVENT_COUNT-1:0] rise;
    logic [`EVENT_COUNT-1:0] flags;

    modport capture
    (
        input raw,
        input clear,
        output rise,
        output flags
    );

    modport owner
    (
        output raw,
        output clear,
        input rise,
        input flags
    );
endinterface

// File: rtl/event_capture.sv
`timescale 1ns/10ps
`include "hub_irq_defines.svh"

module event_capture
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Event levels in, sticky flags out
    event_bus_if.capture bus
);

    hub_irq_pkg::capture_state_type state;
    hub_irq_pkg::capture_state_type next_state;

    ////////////////////////////////////////////////////////////////////////
    // Rising edge of each active-high event level
    assign bus.rise = bus.raw & ~state.prev;
    assign bus.flags = state.flags;

    always_comb
    begin
        next_state = state;
        next_state.prev = bus.raw;
        // Set wins over a zero write in the same cycle
        next_state.flags = (state.flags & ~bus.clear) | bus.rise;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            state <= '0;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-flag checks
    genvar i;
    generate
        for (i = 0; i < `EVENT_COUNT; i = i + 1)
        begin : g_flag
            a_flag_sets_edge: assert property (
                @(posedge sys_clk) disable iff (!resetn)
                bus.rise[i] |=> bus.flags[i]
                ##1 (bus.flags[i] || $past(bus.clear[i])))
            else $error("flag missed its event");

            a_flag_holds_one: assert property (
                @(posedge sys_clk) disable iff (!resetn)
                bus.flags[i] && !bus.clear[i] |=> bus.flags[i])
            else $error("flag dropped without a zero write");

            a_flag_zero_clear: assert property (
                @(posedge sys_clk) disable iff (!resetn)
                bus.flags[i] && bus.clear[i] && !bus.rise[i] |=> !bus.flags[i])
            else $error("flag kept after zero write");
        end
    endgenerate

endmodule

// File: test/host_processor_model.sv
`timescale 1ns/10ps
module host_processor_model
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_write_data
);
    initial
    begin
        reg_addr = 8'h5a;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_write_data = 8'ha5;
    end

    // Idle lines show inverted leftovers, never stale values
    task automatic release_bus();
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = ~reg_addr;
        reg_write_data = ~reg_write_data;
    endtask

    // Zero bits clear status, one bits leave it alone
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_write_data = d;
        reg_write = 1'b1;
        @(posedge sys_clk);
        #1;
        release_bus();
        // One idle edge so the next request never reuses this time step
        @(posedge sys_clk);
        #1;
    endtask

    task automatic read_reg(input logic [7:0] a);
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge sys_clk);
        #1;
        release_bus();
        @(posedge sys_clk);
        #1;
    endtask
endmodule

// File: test/tb_hub_serial_port_interrupt_logic.sv
`timescale 1ns/10ps
module tb_hub_serial_port_interrupt_logic;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] ev = 5'h00;
    logic mode = 1'b0;
    logic [1:0] asel = 2'b00;
    logic [4:0] en;
    logic [7:0] exp, seed = 8'h1a;
    logic [7:0] reg_addr, reg_write_data, reg_read_data;
    logic reg_write, reg_read, irq_low;
    logic [6:0] slave_address;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int checked = 0;

    always #50 sys_clk = ~sys_clk;

    hub_serial_port_interrupt_logic i_hub_serial_port_interrupt_logic
    (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read),
        .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
        .suspend_state(ev[4]), .configured_state(ev[3]),
        .port_power_written(ev[2]), .charger_found_low(~ev[1]),
        .detection_finished(ev[0]), .irq_as_suspend_level(mode),
        .addr_select_upper_pin(asel[1]), .addr_select_lower_pin(asel[0]),
        .irq_low(irq_low), .slave_address(slave_address)
    );

    host_processor_model i_host_processor_model
    (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_write_data(reg_write_data)
    );

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host_processor_model.write_reg(a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host_processor_model.read_reg(a);
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Read data lands one edge after the strobe
    always @(posedge sys_clk)
        if (reg_read === 1'b1)
        begin
            #2;
            cmp("reg_read_data", exp_q.pop_front(), reg_read_data);
        end

    initial
    begin
        #(5000 * 100);
        n_mismatch++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(3);
        resetn = 1'b1;
        tick(1);
        cmp("irq_low", 8'h01, {7'h00, irq_low});
        rd(8'he8, 8'h00);
        rd(8'he9, 8'h00);
        rd(8'hea, 8'h08);
        rd(8'h00, 8'h00);
        wr(8'hea, 8'hff);
        rd(8'hea, 8'h08);
        cmp("slave_address", 8'h08, {1'b0, slave_address});
        asel = 2'b11;
        tick(4);
        cmp("slave_address", 8'h29, {1'b0, slave_address});
        $display("test reset and address done");
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 5; i++)
            begin
                seed = lfsr(seed);
                en = p[0] ? ~seed[4:0] : seed[4:0];
                wr(8'he9, {seed[7:5], en});
                rd(8'he9, {3'h0, en});
                ev[i] = 1'b1;
                tick(2);
                ev[i] = 1'b0;
                exp = {en[i], 2'b00, 5'h01 << i};
                cmp("irq_low", {7'h00, ~en[i]}, {7'h00, irq_low});
                wr(8'he8, 8'hff);
                rd(8'he8, exp);
                wr(8'he8, 8'h7f & ~(8'h01 << i));
                rd(8'he8, 8'h00);
                cmp("irq_low", 8'h01, {7'h00, irq_low});
            end
        $display("test event flags done");
        wr(8'he9, 8'h1f);
        rd(8'he9, 8'h1f);
        ev = 5'h1f;
        tick(2);
        cmp("irq_low", 8'h00, {7'h00, irq_low});
        ev = 5'h00;
        wr(8'he8, 8'h7f);
        rd(8'he8, 8'h1f);
        cmp("irq_low", 8'h01, {7'h00, irq_low});
        wr(8'he8, 8'h00);
        mode = 1'b1;
        ev[4] = 1'b1;
        tick(2);
        cmp("irq_low", 8'h00, {7'h00, irq_low});
        ev[4] = 1'b0;
        tick(2);
        cmp("irq_low", 8'h01, {7'h00, irq_low});
        $display("test summary and suspend level done");
        tick(2);
        conclude();
    end
endmodule
